// [logic/agu_pkg.sv]
/*
  Constants shared by the dual address generator block: register offsets,
  field positions, reset values and addressing mode codes.
  Assumes a 16-bit data path and a 32-bit AHB-Lite register bus.
*/
package agu_pkg;

  // ----------------------------------------------------------------------
  // Register indices, one word each; byte address is four times these
  // ----------------------------------------------------------------------
  localparam logic [7:0] AGU_OFS_CTRL = 8'h46;
  localparam logic [7:0] AGU_OFS_XSTART = 8'h48;
  localparam logic [7:0] AGU_OFS_XEND = 8'h4A;
  localparam logic [7:0] AGU_OFS_YSTART = 8'h4C;
  localparam logic [7:0] AGU_OFS_YEND = 8'h4E;
  localparam logic [7:0] AGU_OFS_BREV = 8'h50;
  localparam logic [7:0] AGU_IDX_CTRL = 8'h46;
  localparam logic [7:0] AGU_IDX_XSTART = 8'h48;
  localparam logic [7:0] AGU_IDX_XEND = 8'h4A;
  localparam logic [7:0] AGU_IDX_YSTART = 8'h4C;
  localparam logic [7:0] AGU_IDX_YEND = 8'h4E;
  localparam logic [7:0] AGU_IDX_BREV = 8'h50;
  localparam logic [7:0] AGU_IDX_STATUS = 8'h54;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int AGU_BIT_XEN = 15;
  localparam int AGU_BIT_YEN = 14;
  localparam int AGU_POS_BSEL = 8;
  localparam int AGU_POS_YSEL = 4;
  localparam int AGU_POS_XSEL = 0;
  localparam int AGU_BIT_BITREV_ENABLE = 15;
  localparam logic [3:0] AGU_SEL_NONE = 4'hF;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] AGU_RST_CTRL = 16'h0000;
  localparam logic [15:0] AGU_RST_START = 16'h0000;
  localparam logic [15:0] AGU_RST_END = 16'h0001;
  localparam logic [15:0] AGU_RST_BREV = 16'h0000;

  // ----------------------------------------------------------------------
  // Addressing modes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    AGU_M_FILE = 4'b0000,
    AGU_M_DIRECT = 4'b0001,
    AGU_M_IND = 4'b0010,
    AGU_M_POST_INC = 4'b0011,
    AGU_M_POST_DEC = 4'b0100,
    AGU_M_PRE_INC = 4'b0101,
    AGU_M_PRE_DEC = 4'b0110,
    AGU_M_REG_OFS = 4'b0111,
    AGU_M_LIT_OFS = 4'b1000
  } agu_mode_t;

  typedef enum logic [1:0] {
    AGU_OP2_REG = 2'b00,
    AGU_OP2_MEM = 2'b01,
    AGU_OP2_LIT5 = 2'b10,
    AGU_OP2_LIT10 = 2'b11
  } agu_op2_t;

  localparam int AGU_NEAR_BITS = 13;
  localparam int AGU_LIT5_BITS = 5;
  localparam int AGU_LIT10_BITS = 10;
  localparam logic [3:0] AGU_WREG0 = 4'h0;

endpackage : agu_pkg

// [logic/agu_top.sv]
/*
  Dual address generator: X and Y effective address units, operand routing
  for three-operand instructions and the circular / bit-reversed control
  registers behind an AHB-Lite slave.
  Assumes the decoder presents one access per unit per cycle, holds the
  pointer values combinationally, and writes back the pointer update.
*/
// Contract
// [R1] Two independent units, X and Y.
// [R2] Y unit serves word reads, MAC only.
// [R3] Linear, circular and bit-reversed addressing supported.
// [R4] Linear and circular usable in both spaces.
// [R5] Bit-reversed applies to data space only.
// [R6] File address is 13 bits, near area.
// [R7] File instructions default to working register zero.
// [R8] Result goes to file or default register.
// [R9] Move addresses whole data space.
// [R10] Plain indirect address equals pointer.
// [R11] Post-modify: use pointer, then adjust.
// [R12] Pre-modify: adjust first, use result.
// [R13] Register offset: pointer plus base register.
// [R14] Literal offset: pointer plus instruction literal.
// [R15] Three-operand first operand is register direct.
// [R16] Second operand: register, memory or 5-bit literal.
// [R17] Result to register or memory.
// [R18] Literals of 5 or 10 bits accepted.
// [R19] X circular needs enable and select not 15.
// [R20] Y circular needs enable and select not 15.
// [R21] Bit-reverse needs select, enable, pre/post increment.
// [R22] Addresses computed combinationally, no stall.
// [R23] Circular start register bit zero reads zero.
`timescale 1ns/100ps
module agu_top (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_x_valid,
  input wire agu_pkg::agu_mode_t i_x_mode,
  input wire logic i_x_prog_space,
  input wire logic i_x_is_move,
  input wire logic i_x_is_write,
  input wire logic [3:0] i_x_ptr_sel,
  input wire logic [15:0] i_x_ptr,
  input wire logic [15:0] i_x_base,
  input wire logic [15:0] i_x_lit,
  input wire logic [15:0] i_x_step,
  input wire logic [15:0] i_file_addr,
  output logic [15:0] o_x_addr,
  output logic [15:0] o_x_ptr_next,
  output logic o_x_ptr_we,
  output logic o_x_read_en,
  input wire logic i_y_valid,
  input wire logic i_y_is_mac,
  input wire agu_pkg::agu_mode_t i_y_mode,
  input wire logic [3:0] i_y_ptr_sel,
  input wire logic [15:0] i_y_ptr,
  input wire logic [15:0] i_y_base,
  input wire logic [15:0] i_y_step,
  output logic [15:0] o_y_addr,
  output logic [15:0] o_y_ptr_next,
  output logic o_y_ptr_we,
  output logic o_y_read_en,
  input wire logic i_file_to_default_working_reg,
  input wire logic i_is_mul,
  output logic [3:0] o_default_working_reg,
  output logic o_result_to_file,
  input wire agu_pkg::agu_op2_t i_op2_src,
  input wire logic [15:0] i_op2_reg,
  input wire logic [15:0] i_op2_mem,
  input wire logic [9:0] i_op2_lit,
  input wire logic [15:0] i_op1_reg,
  input wire logic i_result_to_mem,
  output logic [15:0] o_op1,
  output logic [15:0] o_op2,
  output logic o_result_mem_we,
  output logic o_result_reg_we,
  output logic o_x_circ_active,
  output logic o_y_circ_active,
  output logic o_bitrev_active
);
  import agu_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic circ_on(input logic en, input logic [3:0] sel,
                                   input logic [3:0] ptr);
    circ_on = en && (sel != AGU_SEL_NONE) && (sel == ptr);
  endfunction : circ_on

  function automatic logic [15:0] wrap(input logic [15:0] a,
                                       input logic [15:0] s,
                                       input logic [15:0] e,
                                       input logic on);
    // Simple boundary fold; full multi-wrap correction is not modelled.
    if (on && (a > e)) wrap = 16'(a - e - 16'h0002 + s);
    else if (on && (a < s)) wrap = 16'(e + 16'h0002 - (s - a));
    else wrap = a;
  endfunction : wrap

  function automatic logic [15:0] brev_add(input logic [15:0] a,
                                           input logic [14:0] m);
    logic [15:0] ra;
    logic [15:0] rm;
    ra = {<<{a}};
    rm = {<<{{1'b0, m}}};
    brev_add = {<<{16'(ra + rm)}};
  endfunction : brev_add

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] xs_reg;
  logic [15:0] xe_reg;
  logic [15:0] ys_reg;
  logic [15:0] ye_reg;
  logic [15:0] brev_reg;
  logic [2:0] stat_reg;
  logic dp_wr_reg;
  logic dp_rd_reg;
  logic [7:0] dp_ofs_reg;

  wire logic x_circ_enable = ctrl_reg[AGU_BIT_XEN];
  wire logic y_circ_enable = ctrl_reg[AGU_BIT_YEN];
  wire logic [3:0] bitrev_pointer_select = ctrl_reg[AGU_POS_BSEL +: 4];
  wire logic [3:0] y_circ_pointer_select = ctrl_reg[AGU_POS_YSEL +: 4];
  wire logic [3:0] x_circ_pointer_select = ctrl_reg[AGU_POS_XSEL +: 4];
  wire logic bitrev_enable = brev_reg[AGU_BIT_BITREV_ENABLE];
  wire logic [14:0] bitrev_modifier = brev_reg[14:0];

  // ----------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------------
  wire logic bus_go = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dp_wr_reg <= 1'b0;
      dp_rd_reg <= 1'b0;
      dp_ofs_reg <= 8'h00;
    end else begin
      dp_wr_reg <= bus_go && i_hwrite;
      dp_rd_reg <= bus_go && !i_hwrite;
      // Each register owns a whole word, so the word address is the index.
      if (bus_go) dp_ofs_reg <= i_haddr[9:2];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= AGU_RST_CTRL;
      xs_reg <= AGU_RST_START;
      xe_reg <= AGU_RST_END;
      ys_reg <= AGU_RST_START;
      ye_reg <= AGU_RST_END;
      brev_reg <= AGU_RST_BREV;
    end else if (dp_wr_reg) begin
      case (dp_ofs_reg)
        AGU_OFS_CTRL: ctrl_reg <= i_hwdata[15:0];
        AGU_OFS_XSTART: xs_reg <= {i_hwdata[15:1], 1'b0}; // [R23]
        AGU_OFS_XEND: xe_reg <= {i_hwdata[15:1], 1'b1};
        AGU_OFS_YSTART: ys_reg <= {i_hwdata[15:1], 1'b0}; // [R23]
        AGU_OFS_YEND: ye_reg <= {i_hwdata[15:1], 1'b1};
        AGU_OFS_BREV: brev_reg <= i_hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h00000000;
    end else if (bus_go && !i_hwrite) begin
      case (i_haddr[9:2])
        AGU_OFS_CTRL: o_hrdata <= {16'h0000, ctrl_reg};
        AGU_OFS_XSTART: o_hrdata <= {16'h0000, xs_reg};
        AGU_OFS_XEND: o_hrdata <= {16'h0000, xe_reg};
        AGU_OFS_YSTART: o_hrdata <= {16'h0000, ys_reg};
        AGU_OFS_YEND: o_hrdata <= {16'h0000, ye_reg};
        AGU_OFS_BREV: o_hrdata <= {16'h0000, brev_reg};
        AGU_IDX_STATUS: o_hrdata <= {29'h0, stat_reg};
        default: o_hrdata <= 32'h00000000;
      endcase
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ----------------------------------------------------------------------
  // X address unit
  // ----------------------------------------------------------------------
  // Computed combinationally so pointer write-back costs no stall. [R22]
  logic [15:0] x_mod;
  logic x_circ;
  logic x_brev;
  always_comb begin
    x_circ = circ_on(x_circ_enable, x_circ_pointer_select,
                     i_x_ptr_sel); // [R19] [R4]
    x_brev = bitrev_enable && (bitrev_pointer_select != AGU_SEL_NONE)
      && (bitrev_pointer_select == i_x_ptr_sel) && !i_x_prog_space
      && i_x_is_write && ((i_x_mode == AGU_M_PRE_INC)
      || (i_x_mode == AGU_M_POST_INC)); // [R21] [R5]
    x_mod = i_x_ptr;
    o_x_ptr_we = 1'b0;
    o_x_addr = i_x_ptr; // [R10]
    case (i_x_mode)
      AGU_M_FILE: begin
        o_x_addr = i_x_is_move ? i_file_addr // [R9]
          : {3'b000, i_file_addr[AGU_NEAR_BITS-1:0]}; // [R6]
      end
      AGU_M_DIRECT, AGU_M_IND: o_x_addr = i_x_ptr; // [R10]
      AGU_M_POST_INC, AGU_M_PRE_INC: begin
        x_mod = x_brev ? brev_add(i_x_ptr, bitrev_modifier) // [R3]
          : wrap(16'(i_x_ptr + i_x_step), xs_reg, xe_reg, x_circ);
        o_x_ptr_we = 1'b1;
        o_x_addr = (i_x_mode == AGU_M_PRE_INC) ? x_mod // [R12]
          : i_x_ptr; // [R11]
      end
      AGU_M_POST_DEC, AGU_M_PRE_DEC: begin
        x_mod = wrap(16'(i_x_ptr - i_x_step), xs_reg, xe_reg, x_circ);
        o_x_ptr_we = 1'b1;
        o_x_addr = (i_x_mode == AGU_M_PRE_DEC) ? x_mod : i_x_ptr;
      end
      AGU_M_REG_OFS: o_x_addr = wrap(16'(i_x_ptr + i_x_base), xs_reg,
                                     xe_reg, x_circ); // [R13]
      AGU_M_LIT_OFS: o_x_addr = wrap(16'(i_x_ptr + i_x_lit), xs_reg,
                                     xe_reg, x_circ); // [R14]
      default: o_x_addr = i_x_ptr;
    endcase
    o_x_ptr_we = o_x_ptr_we && i_x_valid;
    o_x_ptr_next = x_mod;
  end
  assign o_x_read_en = i_x_valid && !i_x_is_write;

  // ----------------------------------------------------------------------
  // Y address unit, independent of X
  // ----------------------------------------------------------------------
  logic [15:0] y_mod;
  logic y_circ;
  logic y_ok;
  always_comb begin
    y_ok = i_y_valid && i_y_is_mac; // [R2] [R1]
    y_circ = circ_on(y_circ_enable, y_circ_pointer_select,
                     i_y_ptr_sel); // [R20]
    y_mod = i_y_ptr;
    o_y_ptr_we = 1'b0;
    o_y_addr = {i_y_ptr[15:1], 1'b0};
    case (i_y_mode)
      AGU_M_POST_INC: begin
        y_mod = wrap(16'(i_y_ptr + i_y_step), ys_reg, ye_reg, y_circ);
        o_y_ptr_we = y_ok; // [R11]
      end
      AGU_M_REG_OFS: o_y_addr = {16'(i_y_ptr + i_y_base)}
        & 16'hFFFE; // [R13]
      default: o_y_addr = {i_y_ptr[15:1], 1'b0}; // [R10]
    endcase
    o_y_ptr_next = {y_mod[15:1], 1'b0};
  end
  assign o_y_read_en = y_ok; // [R2]

  // ----------------------------------------------------------------------
  // Operand routing
  // ----------------------------------------------------------------------
  // File instructions default to working register zero. [R7]
  assign o_default_working_reg = AGU_WREG0;
  // Multiply bypasses the file destination and never sends its result to the file register. [R8]
  assign o_result_to_file = !i_file_to_default_working_reg && !i_is_mul;
  assign o_op1 = i_op1_reg; // [R15]
  always_comb begin
    case (i_op2_src) // [R16] [R18]
      AGU_OP2_REG: o_op2 = i_op2_reg;
      AGU_OP2_MEM: o_op2 = i_op2_mem;
      AGU_OP2_LIT5: o_op2 = {11'h000, i_op2_lit[AGU_LIT5_BITS-1:0]};
      AGU_OP2_LIT10: o_op2 = {6'h00, i_op2_lit[AGU_LIT10_BITS-1:0]};
      default: o_op2 = i_op2_reg;
    endcase
  end
  assign o_result_mem_we = i_result_to_mem; // [R17]
  assign o_result_reg_we = !i_result_to_mem; // [R17]

  // ----------------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) stat_reg <= 3'b000;
    else stat_reg <= {x_brev, y_circ, x_circ};
  end
  assign o_x_circ_active = x_circ;
  assign o_y_circ_active = y_circ;
  assign o_bitrev_active = x_brev;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_IND: assert property ( // [R10]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_IND |-> o_x_addr == i_x_ptr)
    else $error("Indirect address differs from pointer.");
  AST_POST: assert property ( // [R11]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_POST_INC |-> o_x_addr == i_x_ptr)
    else $error("Post-modify used modified address.");
  AST_POSTDEC: assert property ( // [R11]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_POST_DEC |-> o_x_addr == i_x_ptr)
    else $error("Post-decrement used modified address.");
  AST_PRE: assert property ( // [R12]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_PRE_INC && !x_circ && !x_brev
    |-> o_x_addr == 16'(i_x_ptr + i_x_step))
    else $error("Pre-modify address wrong.");
  AST_REGOFS: assert property ( // [R13]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_REG_OFS && !x_circ
    |-> o_x_addr == 16'(i_x_ptr + i_x_base))
    else $error("Register offset address wrong.");
  AST_LIT: assert property ( // [R14]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_LIT_OFS && !x_circ
    |-> o_x_addr == 16'(i_x_ptr + i_x_lit))
    else $error("Literal offset address wrong.");
  AST_NOWB: assert property ( // [R14]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_x_mode == AGU_M_REG_OFS || i_x_mode == AGU_M_LIT_OFS)
    |-> !o_x_ptr_we)
    else $error("Offset mode wrote back the pointer.");
  AST_NEAR: assert property ( // [R6]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_FILE && !i_x_is_move |-> o_x_addr[15:13] == 3'b000)
    else $error("File address left near area.");
  AST_MOVE: assert property ( // [R9]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_x_mode == AGU_M_FILE && i_x_is_move |-> o_x_addr == i_file_addr)
    else $error("Move did not reach the full data space.");
  AST_MUL: assert property ( // [R8]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_is_mul |-> !o_result_to_file)
    else $error("Multiply result sent to the file register.");
  AST_LIT5: assert property ( // [R16]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_op2_src == AGU_OP2_LIT5 |-> o_op2[15:5] == 11'h000)
    else $error("Short literal carried upper bits.");
  AST_XCIRC: assert property ( // [R19]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    x_circ |-> x_circ_enable && x_circ_pointer_select != 4'hF)
    else $error("X circular active while disabled.");
  AST_YCIRC: assert property ( // [R20]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    y_circ |-> y_circ_enable && y_circ_pointer_select != 4'hF)
    else $error("Y circular active while disabled.");
  AST_BREV: assert property ( // [R21]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    x_brev |-> !i_x_prog_space && bitrev_enable)
    else $error("Bit-reverse active outside its conditions.");
  AST_YMAC: assert property ( // [R2]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_y_read_en |-> i_y_is_mac)
    else $error("Y unit read outside multiply-accumulate.");
  AST_YWORD: assert property ( // [R2]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_y_read_en |-> !o_y_addr[0])
    else $error("Y unit read was not word aligned.");
  AST_START: assert property ( // [R23]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    dp_wr_reg && dp_ofs_reg == AGU_OFS_XSTART |=> xs_reg[0] == 1'b0)
    else $error("Start register low bit set.");
  AST_STAT: assert property ( // [R3]
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    x_circ |=> stat_reg[0])
    else $error("Status did not capture X circular.");

endmodule : agu_top

// [test/agu_core_model.sv]
/*
  Behavioural model of the core's working register file as seen by the
  address units: it hands out pointer and base values and takes the
  pointer write-backs.
  Assumes one clock, a synchronous active-low reset and a bench load port.
*/
`timescale 1ns/100ps
module agu_core_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_x_sel,
  input wire logic [3:0] i_y_sel,
  input wire logic [3:0] i_b_sel,
  input wire logic i_x_we,
  input wire logic [15:0] i_x_next,
  input wire logic i_y_we,
  input wire logic [15:0] i_y_next,
  input wire logic i_load_en,
  input wire logic [3:0] i_load_idx,
  input wire logic [15:0] i_load_val,
  output logic [15:0] o_x_ptr,
  output logic [15:0] o_y_ptr,
  output logic [15:0] o_base
);
  logic [15:0] default_working_reg_reg [16];

  // Pointers are read with no delay, so the unit may form the address
  // in the same cycle as the access.
  assign o_x_ptr = default_working_reg_reg[i_x_sel];
  assign o_y_ptr = default_working_reg_reg[i_y_sel];
  assign o_base = default_working_reg_reg[i_b_sel];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 16; i++) begin
        default_working_reg_reg[i] <= 16'h0000;
      end
    end else begin
      if (i_load_en) begin
        default_working_reg_reg[i_load_idx] <= i_load_val;
      end
      if (i_x_we) begin
        default_working_reg_reg[i_x_sel] <= i_x_next;
      end
      if (i_y_we) begin
        default_working_reg_reg[i_y_sel] <= i_y_next;
      end
    end
  end
endmodule : agu_core_model

// [test/test_agu_top.sv]
/*
  Self-checking bench for the dual address generator block.
  Assumes the block answers every bus transfer with no wait state.
*/
`timescale 1ns/100ps
module test_agu_top;
  import agu_pkg::*;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hrdy, hresp, x_valid = 0, x_prog = 0, x_move = 0, x_wr = 0;
  agu_mode_t x_mode = AGU_M_FILE, y_mode = AGU_M_IND;
  logic [3:0] x_sel = 4'h2, y_sel = 4'hA, b_sel = 4'h3, dwr, ld_idx = 0;
  logic [15:0] x_ptr, y_ptr, base, x_lit = 16'h0010, step = 16'h0002;
  logic [15:0] file_addr = 0, x_addr, x_nxt, y_addr, y_nxt, ld_val = 0;
  logic x_we, x_ren, y_we, y_ren, y_valid = 0, y_mac = 0, ld_en = 0;
  logic f2w = 0, mul = 0, r2f, r2m = 0, mwe, rwe, xc, yc, br;
  agu_op2_t op2src = AGU_OP2_REG;
  logic [9:0] op2lit = 10'h3FF;
  logic [15:0] op1, op2;
  logic [31:0] r;
  int n_fail = 0, comparisons = 0;

  always #5 clk = ~clk;

  agu_top u_agu_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_x_valid(x_valid), .i_x_mode(x_mode), .i_x_prog_space(x_prog),
    .i_x_is_move(x_move), .i_x_is_write(x_wr), .i_x_ptr_sel(x_sel),
    .i_x_ptr(x_ptr), .i_x_base(base), .i_x_lit(x_lit), .i_x_step(step),
    .i_file_addr(file_addr), .o_x_addr(x_addr), .o_x_ptr_next(x_nxt),
    .o_x_ptr_we(x_we), .o_x_read_en(x_ren), .i_y_valid(y_valid),
    .i_y_is_mac(y_mac), .i_y_mode(y_mode), .i_y_ptr_sel(y_sel),
    .i_y_ptr(y_ptr), .i_y_base(base), .i_y_step(step), .o_y_addr(y_addr),
    .o_y_ptr_next(y_nxt), .o_y_ptr_we(y_we), .o_y_read_en(y_ren),
    .i_file_to_default_working_reg(f2w), .i_is_mul(mul), .o_default_working_reg(dwr),
    .o_result_to_file(r2f), .i_op2_src(op2src), .i_op2_reg(16'h1111),
    .i_op2_mem(16'h2222), .i_op2_lit(op2lit), .i_op1_reg(16'h0ABC),
    .i_result_to_mem(r2m), .o_op1(op1), .o_op2(op2),
    .o_result_mem_we(mwe), .o_result_reg_we(rwe), .o_x_circ_active(xc),
    .o_y_circ_active(yc), .o_bitrev_active(br));

  agu_core_model u_agu_core_model (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_x_sel(x_sel), .i_y_sel(y_sel), .i_b_sel(b_sel), .i_x_we(x_we),
    .i_x_next(x_nxt), .i_y_we(y_we), .i_y_next(y_nxt), .i_load_en(ld_en),
    .i_load_idx(ld_idx), .i_load_val(ld_val), .o_x_ptr(x_ptr),
    .o_y_ptr(y_ptr), .o_base(base));

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // ----------------------------------------------------------------------
  // Bus and register file helpers
  // ----------------------------------------------------------------------
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      close_out();
    end
  endtask : wait_rdy

  // Register index times four is the byte address on the bus.
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask : bus

  task automatic load(input logic [3:0] i, input logic [15:0] v);
    ld_en <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    @(posedge clk);
    ld_en <= 1'b0;
  endtask : load

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] idx [6];
    logic [15:0] rv [6];
    idx = '{AGU_IDX_CTRL, AGU_IDX_XSTART, AGU_IDX_XEND, AGU_IDX_YSTART,
            AGU_IDX_YEND, AGU_IDX_BREV};
    rv = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, idx[i], 32'h0);
      chk(r, {16'h0, rv[i]});
    end
    bus(1'b1, AGU_IDX_XSTART, 32'h1235);
    bus(1'b0, AGU_IDX_XSTART, 32'h0);
    chk(r, 32'h1234);
    bus(1'b1, AGU_IDX_YSTART, 32'h0F0F);
    bus(1'b0, AGU_IDX_YSTART, 32'h0);
    chk(r, 32'h0F0E);
    bus(1'b1, 8'h60, 32'hFFFF);
    bus(1'b0, 8'h60, 32'h0);
    chk(r, 32'h0);
    chk(hresp, 1'b0);
    bus(1'b1, AGU_IDX_CTRL, 32'hCFFF);
    bus(1'b0, AGU_IDX_CTRL, 32'h0);
    chk(r, 32'hCFFF);
  endtask : t_regs

  task automatic x_run(input agu_mode_t m, input logic [15:0] ea,
                       input logic [15:0] nx);
    load(4'h2, 16'h0100);
    x_valid <= 1'b1;
    x_mode <= m;
    @(negedge clk);
    chk(x_addr, ea);
    @(posedge clk);
    x_valid <= 1'b0;
    @(negedge clk);
    chk(x_ptr, nx);
    @(posedge clk);
  endtask : x_run

  task automatic t_x();
    load(4'h3, 16'h0040);
    @(posedge clk);
    x_run(AGU_M_IND, 16'h0100, 16'h0100);
    x_run(AGU_M_POST_INC, 16'h0100, 16'h0102);
    x_run(AGU_M_POST_DEC, 16'h0100, 16'h00FE);
    x_run(AGU_M_PRE_INC, 16'h0102, 16'h0102);
    x_run(AGU_M_PRE_DEC, 16'h00FE, 16'h00FE);
    x_run(AGU_M_REG_OFS, 16'h0140, 16'h0100);
    x_run(AGU_M_LIT_OFS, 16'h0110, 16'h0100);
  endtask : t_x

  task automatic t_file();
    x_valid <= 1'b1;
    x_mode <= AGU_M_FILE;
    file_addr <= 16'hFFFE;
    f2w <= 1'b1;
    @(negedge clk);
    chk(x_addr, 16'h1FFE);
    chk(dwr, AGU_WREG0);
    chk(r2f, 1'b0);
    @(posedge clk);
    x_move <= 1'b1;
    f2w <= 1'b0;
    @(negedge clk);
    chk(x_addr, 16'hFFFE);
    chk(r2f, 1'b1);
    chk(x_ren, 1'b1);
    @(posedge clk);
    mul <= 1'b1;
    @(negedge clk);
    chk(r2f, 1'b0);
    @(posedge clk);
    x_valid <= 1'b0;
    x_move <= 1'b0;
    mul <= 1'b0;
  endtask : t_file

  task automatic t_y();
    load(4'hA, 16'h0200);
    y_valid <= 1'b1;
    y_mode <= AGU_M_POST_INC;
    @(negedge clk);
    chk({y_ren, y_we}, 2'b00);
    @(posedge clk);
    y_mac <= 1'b1;
    @(negedge clk);
    chk({y_ren, y_addr}, {1'b1, 16'h0200});
    @(posedge clk);
    y_valid <= 1'b0;
    y_mac <= 1'b0;
    @(negedge clk);
    chk(y_ptr, 16'h0202);
  endtask : t_y

  task automatic t_ops();
    logic [15:0] ev [4];
    ev = '{16'h1111, 16'h2222, 16'h001F, 16'h03FF};
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      op2src <= agu_op2_t'(k);
      r2m <= k[0];
      @(negedge clk);
      chk(op2, ev[k]);
      chk(op1, 16'h0ABC);
      chk({mwe, rwe}, {k[0], ~k[0]});
    end
  endtask : t_ops

  task automatic t_flags();
    x_valid <= 1'b1;
    y_valid <= 1'b1;
    y_mac <= 1'b1;
    x_sel <= 4'hF;
    y_sel <= 4'hF;
    bus(1'b1, AGU_IDX_BREV, 32'h8000);
    @(negedge clk);
    chk({xc, yc, br}, 3'b000);
    @(posedge clk);
    x_sel <= 4'h2;
    y_sel <= 4'hA;
    x_mode <= AGU_M_IND;
    bus(1'b1, AGU_IDX_CTRL, 32'h0000);
    @(negedge clk);
    chk({xc, yc, br}, 3'b000);
    @(posedge clk);
    x_mode <= AGU_M_POST_INC;
    x_wr <= 1'b1;
    bus(1'b1, AGU_IDX_CTRL, 32'hC2A2);
    @(negedge clk);
    chk({xc, yc, br}, 3'b111);
    @(posedge clk);
    bus(1'b0, AGU_IDX_STATUS, 32'h0);
    chk(r, 32'h7);
    x_prog <= 1'b1;
    @(negedge clk);
    chk({xc, br}, 2'b10);
    @(posedge clk);
    x_valid <= 1'b0;
    y_valid <= 1'b0;
    x_wr <= 1'b0;
    x_prog <= 1'b0;
  endtask : t_flags

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_x();
    t_file();
    t_y();
    t_ops();
    @(posedge clk);
    t_flags();
    close_out();
  end
endmodule : test_agu_top
